// ---- logic/dsap_pkg.sv ----
// dsap_pkg: register indexes, field positions, reset values, types and helpers
// assumes a 32-bit apb slave decoding paddr[11:2] as the word index
package dsap_pkg;
  localparam int NCH = 4;
  // word indexes; byte address is four times the index, low ten bits decoded
  localparam logic [31:0] IDX_SRC_HI [NCH] = '{32'hfffff082, 32'hfffff08a, 32'hfffff092,
                                                32'hfffff09a};
  localparam logic [31:0] IDX_SRC_LO [NCH] = '{32'hfffff080, 32'hfffff088, 32'hfffff090,
                                                32'hfffff098};
  localparam logic [31:0] IDX_CTRL [NCH] = '{32'h00000000, 32'h00000001, 32'h00000002,
                                              32'h00000003};
  localparam logic [31:0] IDX_WORK [NCH] = '{32'h00000004, 32'h00000005, 32'h00000006,
                                              32'h00000007};
  localparam logic [31:0] IDX_STATUS = 32'h00000008;
  localparam logic [31:0] IDX_MASK = 32'h00000009;
  localparam logic [3:0] STRB_HALF = 4'h3;
  localparam int HI_SPACE_BIT = 15;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_INIT_BIT = 1;
  localparam int CTRL_SWTRG_BIT = 2;
  localparam int CTRL_TTYP_BIT = 3;
  localparam int CTRL_MODE_LSB = 4;
  localparam int CTRL_UNIT_LSB = 6;
  localparam int CTRL_SEL_LSB = 8;
  localparam int CTRL_CNT_LSB = 16;
  localparam int ST_ERR_LSB = 4;
  localparam logic [15:0] HALF_RST = 16'h0000;
  localparam logic [7:0] STAT_RST = 8'h00;
  localparam logic [3:0] PIN_RST = 4'hf;

  typedef enum logic [1:0] {MODE_SINGLE = 2'b00, MODE_STEP = 2'b01, MODE_BLOCK = 2'b10,
                            MODE_RSVD = 2'b11} dsap_mode_t;
  typedef enum logic [1:0] {SEL_PERIPH = 2'b00, SEL_PIN = 2'b01, SEL_SW = 2'b10,
                            SEL_USB = 2'b11} dsap_sel_t;
  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_SRC = 2'b01, ST_DST = 2'b10} dsap_state_t;

  typedef struct packed {
    logic [15:0] count;
    dsap_sel_t sel;
    logic [1:0] unit;
    dsap_mode_t mode;
    logic ttyp;
    logic en;
  } dsap_ctrl_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic flyby;
    logic data_ram;
    logic [1:0] unit;
    logic [1:0] chan;
    logic [27:0] addr;
  } dsap_beat_t;

  localparam dsap_ctrl_t CTRL_RST = '{count: 16'h0000, sel: SEL_PERIPH, unit: 2'h0,
                                      mode: MODE_SINGLE, ttyp: 1'b0, en: 1'b0};

  function automatic logic [27:0] unit_bytes(input logic [1:0] unit);
    logic [27:0] r;
    r = 28'h0000004;
    if (unit == 2'h0) r = 28'h0000001;
    else if (unit == 2'h1) r = 28'h0000002;
    return r;
  endfunction

  function automatic logic idx_hit(input logic [9:0] widx, input logic [31:0] idx);
    return widx == idx[9:0];
  endfunction
endpackage

// ---- logic/dsap_reqsync.sv ----
// dsap_reqsync: two-flop synchroniser for the external request pins
// assumes pins idle high; the first stage feeds only the second
`timescale 1ns/10ps
module dsap_reqsync import dsap_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [3:0] async_in,
  output logic [3:0] sync_out
);
  logic [3:0] meta_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= PIN_RST;
      sync_out <= PIN_RST;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule // dsap_reqsync

// ---- logic/dsap_chan.sv ----
// dsap_chan: working (slave) source address and unit counter of one channel
// assumes the master copy lives in the register file and load pulses are one cycle
`timescale 1ns/10ps
module dsap_chan import dsap_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [27:0] mst_addr,
  input wire logic mst_ram,
  input wire logic [15:0] cnt_init,
  input wire logic [1:0] unit,
  input wire logic init_p,
  input wire logic beat_done,
  output logic [27:0] slv_addr_q,
  output logic slv_ram_q,
  output logic [15:0] remain_q,
  output logic last,
  output logic tc
);
  logic load;
  logic [27:0] slv_addr_d;
  logic [15:0] remain_d;

  assign last = remain_q == 16'h0000;
  assign tc = beat_done & last;
  // master reaches the slave only on normal end or init
  assign load = init_p | tc;
  assign slv_addr_d = load ? mst_addr :
                      beat_done ? slv_addr_q + unit_bytes(unit) : slv_addr_q;
  // count holds units minus one, so 16 bits give 65536 units
  assign remain_d = load ? cnt_init : beat_done ? remain_q - 16'h0001 : remain_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slv_addr_q <= 28'h0000000;
      slv_ram_q <= 1'b0;
      remain_q <= 16'h0000;
    end else begin
      slv_addr_q <= slv_addr_d;
      slv_ram_q <= load ? mst_ram : slv_ram_q;
      remain_q <= remain_d;
    end
  end
endmodule // dsap_chan

// ---- logic/dsap_top.sv ----
// dsap_top: four-channel source address path with apb registers and beat engine
// assumes an apb4 master on pclk and a system bus that accepts beats on bus_ready
// Functional notes
// - four channels, each with own address, requests and end indication.
// - transfer unit of 8, 16 or 32 bits steps the address.
// - one programming runs up to 65536 units.
// - flyby is one bus beat; two-cycle is a read beat then a write beat.
// - requests come from peripherals, request pins, software or usb.
// - usb requests are ignored in block mode.
// - instruction ram is never read as a source.
// - a per-channel end pulse marks a finished transfer.
// - 28-bit source address in upper and lower 16-bit halves.
// - master copy written by software, working slave copy used by transfers.
// - slave reloads from master only on normal end or init bit.
// - writes after disabling do not reach the slave by themselves.
// - flyby puts the source address on the bus; destination is ignored.
// - half-registers take only 16-bit accesses.
// - lower half holds bits 15 to 0, the next or flyby address.
`timescale 1ns/10ps
module dsap_top import dsap_pkg::*; #(
  parameter logic [27:0] IRAM_BASE = 28'h0000000,
  parameter logic [27:0] IRAM_LAST = 28'h00fffff
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] periph_req,
  input wire logic [3:0] usb_req,
  input wire logic [3:0] external_request_pin_n,
  output dsap_beat_t bus_beat,
  input wire logic bus_ready,
  output logic [3:0] transfer_end_outputs,
  output logic irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  function automatic logic in_iram(input logic ram, input logic [27:0] a);
    return !ram && a >= IRAM_BASE && a <= IRAM_LAST;
  endfunction

  // apb decode
  logic [9:0] widx;
  logic acc;
  logic wr_ok;
  logic [3:0] hit_hi;
  logic [3:0] hit_lo;
  logic [3:0] hit_ctrl;
  logic [3:0] hit_work;
  logic hit_st;
  logic hit_mk;
  logic half_hit;
  logic bad_strb;
  logic mapped;
  logic [31:0] rd_mux;
  logic [31:0] prdata_q;

  // channel state
  dsap_ctrl_t ctrl_q [NCH];
  logic [15:0] mhi_q [NCH];
  logic [15:0] mlo_q [NCH];
  logic [27:0] slv_addr [NCH];
  logic slv_ram [NCH];
  logic [15:0] remain [NCH];
  logic [3:0] last;
  logic [3:0] tc;
  logic [3:0] init_p;
  logic [3:0] sw_p;
  logic [3:0] req_ev;
  logic [3:0] pend_q;
  logic [3:0] pend_clr;
  logic [3:0] iram_bad;
  logic [3:0] ready;
  logic [3:0] done_vec;
  logic [3:0] pin_sync;
  logic [3:0] pin_prev_q;
  logic [3:0] pin_fall;

  // engine and status
  dsap_state_t state_q;
  dsap_state_t state_d;
  dsap_beat_t beat_q;
  dsap_beat_t beat_d;
  logic [1:0] pick;
  logic any_ready;
  logic unit_done;
  logic [7:0] stat_q;
  logic [7:0] mask_q;
  logic [7:0] w1c;
  logic [3:0] tend_q;

  assign widx = paddr[11:2];
  assign acc = psel & penable;
  assign hit_st = idx_hit(widx, IDX_STATUS);
  assign hit_mk = idx_hit(widx, IDX_MASK);
  assign half_hit = |{hit_hi, hit_lo};
  // half-registers refuse any write whose strobe is not exactly the low two byte lanes
  assign bad_strb = pwrite & half_hit & (pstrb != STRB_HALF);
  assign mapped = |{hit_hi, hit_lo, hit_ctrl, hit_work, hit_st, hit_mk};
  assign pslverr = acc & (~mapped | bad_strb);
  assign pready = 1'b1;
  assign wr_ok = acc & pwrite & ~pslverr;
  assign prdata = prdata_q;

  // read data is latched in the setup phase so the access phase sees a flop
  always_comb begin
    rd_mux = 32'h00000000;
    for (int i = 0; i < NCH; i++) begin
      if (hit_hi[i]) rd_mux = {16'h0000, mhi_q[i]};
      if (hit_lo[i]) rd_mux = {16'h0000, mlo_q[i]};
      if (hit_ctrl[i]) rd_mux = {ctrl_q[i].count, 6'h00, ctrl_q[i].sel, ctrl_q[i].unit,
                                 ctrl_q[i].mode, ctrl_q[i].ttyp, 2'h0, ctrl_q[i].en};
      if (hit_work[i]) rd_mux = {slv_ram[i], 3'h0, slv_addr[i]};
    end
    if (hit_st) rd_mux = {24'h000000, stat_q};
    if (hit_mk) rd_mux = {24'h000000, mask_q};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata_q <= 32'h00000000;
    else if (psel & ~penable) prdata_q <= rd_mux;
  end

  // request pins are asynchronous and active low
  dsap_reqsync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(external_request_pin_n),
    .sync_out(pin_sync)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) pin_prev_q <= PIN_RST;
    else pin_prev_q <= pin_sync;
  end
  assign pin_fall = pin_prev_q & ~pin_sync;

  for (genvar c = 0; c < NCH; c++) begin : g_ch
    logic wr_ctrl;
    logic [15:0] cnt_load;
    assign hit_hi[c] = idx_hit(widx, IDX_SRC_HI[c]);
    assign hit_lo[c] = idx_hit(widx, IDX_SRC_LO[c]);
    assign hit_ctrl[c] = idx_hit(widx, IDX_CTRL[c]);
    assign hit_work[c] = idx_hit(widx, IDX_WORK[c]);
    assign wr_ctrl = wr_ok & hit_ctrl[c];
    assign init_p[c] = wr_ctrl & pwdata[CTRL_INIT_BIT];
    assign sw_p[c] = wr_ctrl & pwdata[CTRL_SWTRG_BIT];
    // init takes the count written with it, not the stale stored one
    assign cnt_load = init_p[c] ? pwdata[CTRL_CNT_LSB +: 16] : ctrl_q[c].count;

    // master halves; reserved upper bits 14 to 12 are not stored
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        mhi_q[c] <= HALF_RST;
        mlo_q[c] <= HALF_RST;
      end else begin
        if (wr_ok & hit_hi[c]) mhi_q[c] <= {pwdata[15], 3'h0, pwdata[11:0]};
        if (wr_ok & hit_lo[c]) mlo_q[c] <= pwdata[15:0];
      end
    end

    // hardware drops enable at end or on a forbidden source
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) ctrl_q[c] <= CTRL_RST;
      else if (wr_ctrl) ctrl_q[c] <= '{count: pwdata[31:16],
                                       sel: dsap_sel_t'(pwdata[CTRL_SEL_LSB +: 2]),
                                       unit: pwdata[CTRL_UNIT_LSB +: 2],
                                       mode: dsap_mode_t'(pwdata[CTRL_MODE_LSB +: 2]),
                                       ttyp: pwdata[CTRL_TTYP_BIT],
                                       en: pwdata[CTRL_EN_BIT]};
      else if (tc[c] | iram_bad[c]) ctrl_q[c].en <= 1'b0;
    end

    // slave copy reloads only on init or normal end and steps per unit, never moves on a plain write
    dsap_chan u_chan (
      .pclk(pclk),
      .presetn(presetn),
      .mst_addr({mhi_q[c][11:0], mlo_q[c]}),
      .mst_ram(mhi_q[c][HI_SPACE_BIT]),
      .cnt_init(cnt_load),
      .unit(ctrl_q[c].unit),
      .init_p(init_p[c]),
      .beat_done(done_vec[c]),
      .slv_addr_q(slv_addr[c]),
      .slv_ram_q(slv_ram[c]),
      .remain_q(remain[c]),
      .last(last[c]),
      .tc(tc[c])
    );

    assign req_ev[c] = ctrl_q[c].en & (
      (ctrl_q[c].sel == SEL_PERIPH & periph_req[c]) |
      (ctrl_q[c].sel == SEL_PIN & pin_fall[c]) |
      (ctrl_q[c].sel == SEL_SW & sw_p[c]) |
      (ctrl_q[c].sel == SEL_USB & usb_req[c] & ctrl_q[c].mode != MODE_BLOCK));
    assign done_vec[c] = unit_done & (beat_q.chan == 2'(c));
    assign pend_clr[c] = done_vec[c] & (ctrl_q[c].mode != MODE_BLOCK | last[c]);
    // a source in instruction ram is refused before any beat is issued
    assign iram_bad[c] = pend_q[c] & ctrl_q[c].en & (state_q == ST_IDLE) &
                         in_iram(slv_ram[c], slv_addr[c]);
    assign ready[c] = pend_q[c] & ctrl_q[c].en & ~in_iram(slv_ram[c], slv_addr[c]);

    // a new request in the clearing cycle is kept
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) pend_q[c] <= 1'b0;
      else pend_q[c] <= ctrl_q[c].en & ~iram_bad[c] & (req_ev[c] | (pend_q[c] & ~pend_clr[c]));
    end

    chk_usb_block_gate: assert property (
      (ctrl_q[c].mode == MODE_BLOCK && ctrl_q[c].sel == SEL_USB && !pend_q[c]
       && !wr_ctrl) |=> !pend_q[c])
      else $error("usb request taken in block mode");
    chk_reload_on_end: assert property (
      tc[c] |=> slv_addr[c] == $past({mhi_q[c][11:0], mlo_q[c]}))
      else $error("slave not reloaded at end");
    chk_write_no_copy: assert property (
      (wr_ok && (hit_hi[c] || hit_lo[c]) && !init_p[c] && !done_vec[c])
      |=> $stable(slv_addr[c]))
      else $error("master write leaked into slave");
    chk_end_pulse_flag: assert property (
      tc[c] |=> transfer_end_outputs[c] && stat_q[c] ##1 !transfer_end_outputs[c])
      else $error("end pulse or done flag wrong");
    chk_addr_step_unit: assert property (
      (done_vec[c] && !last[c] && !init_p[c])
      |=> slv_addr[c] == 28'($past(slv_addr[c]) + unit_bytes($past(ctrl_q[c].unit))))
      else $error("source address step wrong");
    chk_count_load: assert property (
      init_p[c] |=> remain[c] == $past(pwdata[CTRL_CNT_LSB +: 16]))
      else $error("unit count not loaded");
  end

  // fixed priority, channel 0 first
  assign pick = ready[0] ? 2'd0 : ready[1] ? 2'd1 : ready[2] ? 2'd2 : 2'd3;
  assign any_ready = |ready;
  assign unit_done = bus_ready & ((state_q == ST_SRC & beat_q.flyby) | state_q == ST_DST);

  always_comb begin
    state_d = state_q;
    beat_d = beat_q;
    unique case (state_q)
      ST_IDLE: begin
        if (any_ready) begin
          state_d = ST_SRC;
          // flyby drives the source address as the external memory address
          beat_d = '{valid: 1'b1, write: 1'b0, flyby: ctrl_q[pick].ttyp,
                     data_ram: slv_ram[pick], unit: ctrl_q[pick].unit, chan: pick,
                     addr: slv_addr[pick]};
        end
      end
      ST_SRC: begin
        if (bus_ready & beat_q.flyby) begin
          state_d = ST_IDLE;
          beat_d.valid = 1'b0;
        end else if (bus_ready) begin
          // write half of a two-cycle unit; its address comes from elsewhere
          state_d = ST_DST;
          beat_d.write = 1'b1;
          beat_d.addr = 28'h0000000;
        end
      end
      ST_DST: begin
        if (bus_ready) begin
          state_d = ST_IDLE;
          beat_d.valid = 1'b0;
        end
      end
      default: begin
        state_d = ST_IDLE;
        beat_d.valid = 1'b0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
      beat_q <= '0;
    end else begin
      state_q <= state_d;
      beat_q <= beat_d;
    end
  end
  assign bus_beat = beat_q;

  // sticky status, set beats write-one-to-clear
  assign w1c = (wr_ok & hit_st) ? pwdata[7:0] : 8'h00;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_q <= STAT_RST;
      mask_q <= STAT_RST;
      tend_q <= 4'h0;
    end else begin
      stat_q <= {iram_bad, tc} | (stat_q & ~w1c);
      if (wr_ok & hit_mk) mask_q <= pwdata[7:0];
      tend_q <= tc;
    end
  end
  assign transfer_end_outputs = tend_q;
  assign irq = |(stat_q & mask_q);

  sequence s_issue;
    state_q == ST_IDLE && any_ready ##1 state_q == ST_SRC;
  endsequence

  chk_src_on_bus: assert property (
    s_issue |-> beat_q.addr == slv_addr[beat_q.chan] && beat_q.flyby == ctrl_q[beat_q.chan].ttyp)
    else $error("issued address is not the working source");
  chk_no_iram_read: assert property (
    (beat_q.valid && !beat_q.write) |-> !in_iram(beat_q.data_ram, beat_q.addr))
    else $error("source read from instruction ram");
  sequence s_write_half;
    state_q == ST_DST && beat_q.valid && beat_q.write && beat_q.addr == 28'h0000000;
  endsequence

  chk_two_cycle_write: assert property (
    (state_q == ST_SRC && bus_ready && !beat_q.flyby) |=> s_write_half)
    else $error("two-cycle unit lacks write beat");
  chk_write_then_idle: assert property (
    (state_q == ST_DST && bus_ready) |=> state_q == ST_IDLE && !beat_q.valid)
    else $error("write beat not closing the unit");
  chk_flyby_single: assert property (
    (state_q == ST_SRC && bus_ready && beat_q.flyby) |=> state_q == ST_IDLE && !beat_q.valid)
    else $error("flyby took more than one beat");
  chk_bad_strobe_err: assert property (
    (acc && pwrite && half_hit && pstrb != STRB_HALF) |-> pslverr && !wr_ok
    ##1 $stable(mhi_q[0]) && $stable(mhi_q[1]) && $stable(mhi_q[2]) && $stable(mhi_q[3]))
    else $error("partial write to half register accepted");
endmodule // dsap_top

// ---- test/dsap_bus_model.sv ----
// dsap_bus_model: system bus stand-in that accepts and logs source path beats
// assumes each beat holds until bus_ready; no data phase is modelled
`timescale 1ns/10ps
module dsap_bus_model import dsap_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire dsap_beat_t bus_beat,
  output logic bus_ready,
  output dsap_beat_t seen_q,
  output logic [7:0] seen_n_q
);
  logic [1:0] wait_q;
  logic slow_q;
  // alternate prompt and two-cycle-late acceptance, so the beat hold is exercised
  assign bus_ready = bus_beat.valid && (wait_q == {slow_q, 1'b0});
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_q <= 2'h0;
      slow_q <= 1'b0;
      seen_q <= '0;
      seen_n_q <= 8'h00;
    end else if (bus_ready) begin
      wait_q <= 2'h0;
      slow_q <= ~slow_q;
      seen_q <= bus_beat;
      seen_n_q <= seen_n_q + 8'h01;
    end else if (bus_beat.valid) begin
      wait_q <= wait_q + 2'h1;
    end
  end
endmodule  // dsap_bus_model

// ---- test/dsap_bench.sv ----
// dsap_bench: apb-driven checks of the source address path and its beats
// assumes dsap_top with its default instruction ram window and the bus model
`timescale 1ns/10ps
module dsap_bench import dsap_pkg::*; ();
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, bus_ready, irq, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb, periph_req, usb_req, pin_n, tend;
  dsap_beat_t beat, seen;
  logic [7:0] seen_n, n0;
  int fails, compares, k;
  int end_cnt [4];
  dsap_sel_t ssel [4] = '{SEL_PERIPH, SEL_PIN, SEL_USB, SEL_USB};
  dsap_mode_t smode [4] = '{MODE_SINGLE, MODE_STEP, MODE_BLOCK, MODE_SINGLE};

  dsap_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .periph_req(periph_req), .usb_req(usb_req),
    .external_request_pin_n(pin_n), .bus_beat(beat), .bus_ready(bus_ready),
    .transfer_end_outputs(tend), .irq(irq));
  dsap_bus_model bm (.pclk(pclk), .presetn(presetn), .bus_beat(beat),
    .bus_ready(bus_ready), .seen_q(seen), .seen_n_q(seen_n));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    for (int i = 0; i < 4; i++) begin
      if (tend[i] === 1'b1) end_cnt[i]++;
    end
  end

  task automatic tally_and_finish();
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [39:0] exp, input logic [39:0] got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic logic [11:0] ba(input logic [31:0] idx);
    return {idx[9:0], 2'b00};
  endfunction

  function automatic logic [31:0] ctl(input logic [1:0] sel, input logic [1:0] mode,
      input logic [1:0] unit, input logic ttyp, input logic [15:0] cnt);
    return (32'(cnt) << CTRL_CNT_LSB) | (32'(sel) << CTRL_SEL_LSB)
      | (32'(unit) << CTRL_UNIT_LSB) | (32'(mode) << CTRL_MODE_LSB)
      | (32'(ttyp) << CTRL_TTYP_BIT);
  endfunction

  function automatic dsap_beat_t bt(input logic wr, input logic fly, input logic ram,
      input logic [1:0] unit, input logic [1:0] ch, input logic [27:0] a);
    return '{1'b1, wr, fly, ram, unit, ch, a};
  endfunction

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
      input logic [3:0] s);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i == 16) begin
      fails++;
      tally_and_finish();
    end
  endtask

  task automatic rdx(input string what, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h00000000, 4'h0);
    chk(what, 40'(exp), 40'(rd));
  endtask

  // half-registers always take the 16-bit strobe; upper bits 14 to 12 stay zero
  task automatic prog(input int ch, input logic [15:0] lo, input logic [15:0] hi,
      input logic [31:0] c);
    apb(1'b1, ba(IDX_SRC_LO[ch]), 32'(lo), STRB_HALF);
    // upper half only written while the channel is idle, never mid-transfer
    apb(1'b1, ba(IDX_SRC_HI[ch]), 32'(hi), STRB_HALF);
    apb(1'b1, ba(IDX_CTRL[ch]), c | 32'h00000003, 4'hf);
  endtask

  task automatic swtrig(input int ch, input logic [31:0] c);
    apb(1'b1, ba(IDX_CTRL[ch]), c | 32'h00000005, 4'hf);
  endtask

  task automatic want(input string what, input dsap_beat_t exp);
    int i;
    for (i = 0; i < 40 && seen_n == n0; i++) @(negedge pclk);
    if (i == 40) begin
      fails++;
      tally_and_finish();
    end
    chk(what, 40'(exp), 40'(seen));
    n0 = n0 + 8'h01;
  endtask

  task automatic nobeat(input string what);
    repeat (20) @(negedge pclk);
    chk(what, 40'(n0), 40'(seen_n));
  endtask

  task automatic fire(input dsap_sel_t sel, input int ch);
    @(posedge pclk);
    if (sel == SEL_PERIPH) periph_req[ch] <= 1'b1;
    if (sel == SEL_USB) usb_req[ch] <= 1'b1;
    if (sel == SEL_PIN) pin_n[ch] <= 1'b0;
    @(posedge pclk);
    periph_req <= 4'h0;
    usb_req <= 4'h0;
    repeat (3) @(posedge pclk);
    pin_n <= 4'hf;
  endtask

  initial begin
    {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    {periph_req, usb_req} = '0;
    pin_n = 4'hf;
    n0 = 8'h00;
    end_cnt = '{0, 0, 0, 0};
    presetn = 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rdx("lo0 reset", ba(IDX_SRC_LO[0]), 32'h00000000);
    apb(1'b1, ba(IDX_SRC_HI[1]), 32'h00008abc, STRB_HALF);
    rdx("hi1 half", ba(IDX_SRC_HI[1]), 32'h00008abc);
    apb(1'b1, ba(IDX_SRC_HI[1]), 32'h00000123, 4'hf);
    chk("hi1 word err", 40'h1, 40'(err));
    rdx("hi1 kept", ba(IDX_SRC_HI[1]), 32'h00008abc);
    rdx("unmapped", 12'h3fc, 32'h00000000);
    chk("unmapped err", 40'h1, 40'(err));
    $display("test registers done");
    // flyby, 4-byte units, two units crossing a 64 KiB line
    prog(0, 16'hfffc, 16'h0010, ctl(SEL_SW, MODE_SINGLE, 2'h2, 1'b1, 16'h0001));
    rdx("work0 init", ba(IDX_WORK[0]), 32'h0010fffc);
    apb(1'b1, ba(IDX_SRC_LO[0]), 32'h00002000, STRB_HALF);
    rdx("work0 held", ba(IDX_WORK[0]), 32'h0010fffc);
    swtrig(0, ctl(SEL_SW, MODE_SINGLE, 2'h2, 1'b1, 16'h0001));
    want("flyby beat 1", bt(1'b0, 1'b1, 1'b0, 2'h2, 2'h0, 28'h010fffc));
    rdx("work0 next", ba(IDX_WORK[0]), 32'h00110000);
    swtrig(0, ctl(SEL_SW, MODE_SINGLE, 2'h2, 1'b1, 16'h0001));
    want("flyby beat 2", bt(1'b0, 1'b1, 1'b0, 2'h2, 2'h0, 28'h0110000));
    repeat (4) @(negedge pclk);
    chk("end0 pulses", 40'h1, 40'(end_cnt[0]));
    rdx("work0 reload", ba(IDX_WORK[0]), 32'h00102000);
    rdx("status done", ba(IDX_STATUS), 32'h00000001);
    chk("irq masked", 40'h0, 40'(irq));
    apb(1'b1, ba(IDX_MASK), 32'h00000001, 4'hf);
    @(negedge pclk);
    chk("irq raised", 40'h1, 40'(irq));
    apb(1'b1, ba(IDX_STATUS), 32'h00000001, 4'hf);
    @(negedge pclk);
    chk("irq cleared", 40'h0, 40'(irq));
    rdx("status clear", ba(IDX_STATUS), 32'h00000000);
    $display("test flyby done");
    apb(1'b1, ba(IDX_SRC_LO[0]), 32'h00003000, STRB_HALF);
    rdx("work0 disabled", ba(IDX_WORK[0]), 32'h00102000);
    apb(1'b1, ba(IDX_CTRL[0]), 32'h00000002, 4'hf);
    rdx("work0 init load", ba(IDX_WORK[0]), 32'h00103000);
    $display("test reload done");
    prog(2, 16'h0100, 16'h0000, ctl(SEL_SW, MODE_SINGLE, 2'h0, 1'b1, 16'h0000));
    swtrig(2, ctl(SEL_SW, MODE_SINGLE, 2'h0, 1'b1, 16'h0000));
    nobeat("iram source beat");
    rdx("iram error", ba(IDX_STATUS), 32'h00000040);
    prog(2, 16'h0100, 16'h8000, ctl(SEL_SW, MODE_SINGLE, 2'h0, 1'b1, 16'h0000));
    swtrig(2, ctl(SEL_SW, MODE_SINGLE, 2'h0, 1'b1, 16'h0000));
    want("data ram beat", bt(1'b0, 1'b1, 1'b1, 2'h0, 2'h2, 28'h0000100));
    $display("test source space done");
    prog(1, 16'h0040, 16'h0020, ctl(SEL_SW, MODE_SINGLE, 2'h0, 1'b0, 16'h0000));
    swtrig(1, ctl(SEL_SW, MODE_SINGLE, 2'h0, 1'b0, 16'h0000));
    want("read beat", bt(1'b0, 1'b0, 1'b0, 2'h0, 2'h1, 28'h0200040));
    want("write beat", bt(1'b1, 1'b0, 1'b0, 2'h0, 2'h1, 28'h0000000));
    repeat (4) @(negedge pclk);
    chk("end1 pulses", 40'h1, 40'(end_cnt[1]));
    $display("test two-cycle done");
    for (k = 0; k < 4; k++) begin
      prog(3, 16'h0010, 16'h0030, ctl(ssel[k], smode[k], 2'h1, 1'b1, 16'h0000));
      fire(ssel[k], 3);
      if (k == 2) begin
        nobeat("usb in block mode");
        apb(1'b1, ba(IDX_CTRL[3]), 32'h00000000, 4'hf);
      end else begin
        want("request beat", bt(1'b0, 1'b1, 1'b0, 2'h1, 2'h3, 28'h0300010));
      end
    end
    $display("test request sources done");
    // block mode: one trigger runs both units of a two-unit count
    prog(0, 16'h0100, 16'h0040, ctl(SEL_SW, MODE_BLOCK, 2'h0, 1'b1, 16'h0001));
    swtrig(0, ctl(SEL_SW, MODE_BLOCK, 2'h0, 1'b1, 16'h0001));
    want("block beat 1", bt(1'b0, 1'b1, 1'b0, 2'h0, 2'h0, 28'h0400100));
    want("block beat 2", bt(1'b0, 1'b1, 1'b0, 2'h0, 2'h0, 28'h0400101));
    $display("test block mode done");
    tally_and_finish();
  end
endmodule  // dsap_bench
